// *** logic/sbg_baud_gen.sv ***
// Functional notes
// - The two-bit first prescaler field selects a shared factor of 1, 3, 4 or 13.
// - The transmit divisor is two to the power of the three-bit transmit rate field.
// - The receive divisor is two to the power of the receive rate field, apart from transmit.
// - A zero transmit fine register leaves the power-of-two divisor alone, else multiplies it.
// - A zero receive fine register leaves the power-of-two divisor alone, else multiplies it.
// - A non-zero receive fine value divides the post divide-by-16 clock by 1 to 255.
// - A non-zero transmit fine value divides the post divide-by-16 clock by 1 to 255.
// - After reset both fine registers and the baud register read zero.
// - Bit rate is bus clock over 16, over the prescale factor and over the rate divisor.
// - Registers decode at indices 50h to 54h and 56h to 58h.
// - With low-power disable set, prescalers, bit ticks and serial enable stop once the current byte ends.
module sbg_baud_gen (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        byte_busy_i,
    output logic             tx_bit_tick_o,
    output logic             rx_bit_tick_o,
    output logic             serial_enable_o,
    output logic      [7:0]  tx_holding_o
);

    sbg_pkg::sbg_baud_t     baud_rate_select;
    logic [7:0]             serial_control_one;
    logic [7:0]             serial_control_two;
    logic [7:0]             receive_fine_divider;
    logic [7:0]             transmit_fine_divider;
    logic [7:0]             serial_data;
    sbg_pkg::sbg_lp_state_t lp_state;
    sbg_pkg::sbg_lp_state_t next_lp_state;

    logic [6:0] reg_idx;
    logic       bus_req;
    logic       wr_take;
    logic       cfg_wr;
    logic       run;
    logic [3:0] prescale;
    logic [3:0] pre_cnt;
    logic       pre_tick;
    logic [1:0] bit_event;

    assign reg_idx = avs_address_i[8:2];
    assign bus_req = avs_read_i | avs_write_i;
    // write lands on the edge where the master sees waitrequest low
    assign wr_take = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign cfg_wr  = wr_take & ((reg_idx == sbg_pkg::IDX_BAUD)
                              | (reg_idx == sbg_pkg::IDX_RX_FINE)
                              | (reg_idx == sbg_pkg::IDX_TX_FINE));
    assign run      = (lp_state != sbg_pkg::LP_STOP);
    assign prescale = sbg_pkg::prescale_factor(baud_rate_select.first_prescaler_field);

    function automatic logic [7:0] read_mux(input logic [6:0] idx);
        case (idx)
            sbg_pkg::IDX_STATUS:   read_mux = sbg_pkg::RST_STATUS;
            sbg_pkg::IDX_DATA:     read_mux = serial_data;
            sbg_pkg::IDX_BAUD:     read_mux = baud_rate_select;
            sbg_pkg::IDX_CTRL_ONE: read_mux = serial_control_one;
            sbg_pkg::IDX_CTRL_TWO: read_mux = serial_control_two;
            sbg_pkg::IDX_RX_FINE:  read_mux = receive_fine_divider;
            sbg_pkg::IDX_TX_FINE:  read_mux = transmit_fine_divider;
            sbg_pkg::IDX_GEN_STAT: read_mux = {6'h00, lp_state};
            default:               read_mux = 8'h00;
        endcase
    endfunction

    // one wait cycle per access: request seen, then answer
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_req && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= {24'h00_0000, read_mux(reg_idx)};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            baud_rate_select      <= sbg_pkg::RST_BAUD;
            receive_fine_divider  <= sbg_pkg::RST_FINE;
            transmit_fine_divider <= sbg_pkg::RST_FINE;
            serial_control_one    <= sbg_pkg::RST_CTRL_ONE;
            serial_control_two    <= sbg_pkg::RST_CTRL_TWO;
            serial_data           <= sbg_pkg::RST_DATA;
        end else if (wr_take) begin
            case (reg_idx)
                sbg_pkg::IDX_DATA:     serial_data           <= avs_writedata_i[7:0];
                sbg_pkg::IDX_BAUD:     baud_rate_select      <= avs_writedata_i[7:0];
                sbg_pkg::IDX_CTRL_ONE: serial_control_one    <= avs_writedata_i[7:0];
                sbg_pkg::IDX_CTRL_TWO: serial_control_two    <= avs_writedata_i[7:0];
                sbg_pkg::IDX_RX_FINE:  receive_fine_divider  <= avs_writedata_i[7:0];
                sbg_pkg::IDX_TX_FINE:  transmit_fine_divider <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end

    // low-power stop waits for the byte in flight
    always_comb begin
        case (lp_state)
            sbg_pkg::LP_RUN: begin
                if (!serial_control_one[sbg_pkg::POS_LOW_POWER]) begin
                    next_lp_state = sbg_pkg::LP_RUN;
                end else if (byte_busy_i) begin
                    next_lp_state = sbg_pkg::LP_DRAIN;
                end else begin
                    next_lp_state = sbg_pkg::LP_STOP;
                end
            end
            sbg_pkg::LP_DRAIN: begin
                if (!serial_control_one[sbg_pkg::POS_LOW_POWER]) begin
                    next_lp_state = sbg_pkg::LP_RUN;
                end else if (!byte_busy_i) begin
                    next_lp_state = sbg_pkg::LP_STOP;
                end else begin
                    next_lp_state = sbg_pkg::LP_DRAIN;
                end
            end
            sbg_pkg::LP_STOP: begin
                if (!serial_control_one[sbg_pkg::POS_LOW_POWER]) begin
                    next_lp_state = sbg_pkg::LP_RUN;
                end else begin
                    next_lp_state = sbg_pkg::LP_STOP;
                end
            end
            default: next_lp_state = sbg_pkg::LP_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lp_state <= sbg_pkg::LP_RUN;
        end else begin
            lp_state <= next_lp_state;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_enable_o <= 1'b0;
            tx_holding_o    <= 8'h00;
        end else begin
            serial_enable_o <= run;
            tx_holding_o    <= serial_data;
        end
    end

    // shared first prescaler; a divider write restarts it cleanly
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_cnt <= 4'h0;
        end else if (!run || cfg_wr || pre_tick) begin
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end
    assign pre_tick = run && !cfg_wr && (pre_cnt == prescale - 4'h1);

    // index 0 transmit, index 1 receive: independent chains
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dir
            logic [2:0] rate;
            logic [7:0] fine;
            logic [7:0] span;
            logic [6:0] div_cnt;
            logic [3:0] os_cnt;
            logic [7:0] fine_cnt;
            logic       div_tick;
            logic       os_tick;

            assign rate = (gi == 0) ? baud_rate_select.transmit_rate_field
                                    : baud_rate_select.receive_rate_field;
            assign fine = (gi == 0) ? transmit_fine_divider : receive_fine_divider;
            assign span = (8'h01 << rate) - 8'h01;

            assign div_tick = pre_tick && (div_cnt == span[6:0]);
            assign os_tick  = div_tick && (os_cnt == sbg_pkg::OVERSAMPLE_LAST);
            // zero fine value bypasses the extended stage
            assign bit_event[gi] = (fine == 8'h00) ? os_tick
                                 : (os_tick && (fine_cnt == fine - 8'h01));

            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    div_cnt <= 7'h00;
                end else if (!run || cfg_wr || div_tick) begin
                    div_cnt <= 7'h00;
                end else if (pre_tick) begin
                    div_cnt <= div_cnt + 7'h01;
                end
            end

            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    os_cnt <= 4'h0;
                end else if (!run || cfg_wr) begin
                    os_cnt <= 4'h0;
                end else if (div_tick) begin
                    os_cnt <= os_cnt + 4'h1;
                end
            end

            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    fine_cnt <= 8'h00;
                end else if (!run || cfg_wr || bit_event[gi]) begin
                    fine_cnt <= 8'h00;
                end else if (os_tick) begin
                    fine_cnt <= fine_cnt + 8'h01;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_bit_tick_o <= 1'b0;
            rx_bit_tick_o <= 1'b0;
        end else begin
            tx_bit_tick_o <= bit_event[0];
            rx_bit_tick_o <= bit_event[1];
        end
    end

    // checking helpers: cycles between bit events per direction
    function automatic logic [31:0] period(input logic [2:0] rate, input logic [7:0] fine);
        logic [31:0] base;
        base = 32'(sbg_pkg::OVERSAMPLE) * 32'(prescale) * (32'h0000_0001 << rate);
        period = (fine == 8'h00) ? base : base * 32'(fine);
    endfunction

    logic [31:0] gap   [2];
    logic [1:0]  seen;
    logic        written;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_gap
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    gap[gi]  <= 32'h0000_0000;
                    seen[gi] <= 1'b0;
                end else if (!run || cfg_wr) begin
                    gap[gi]  <= 32'h0000_0000;
                    seen[gi] <= 1'b0;
                end else if (bit_event[gi]) begin
                    gap[gi]  <= 32'h0000_0000;
                    seen[gi] <= 1'b1;
                end else begin
                    gap[gi]  <= gap[gi] + 32'h0000_0001;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            written <= 1'b0;
        end else if (cfg_wr) begin
            written <= 1'b1;
        end
    end

    sequence s_drain_enter;
        lp_state == sbg_pkg::LP_RUN && serial_control_one[sbg_pkg::POS_LOW_POWER] && byte_busy_i;
    endsequence

    sequence s_byte_done;
        serial_control_one[sbg_pkg::POS_LOW_POWER] && !byte_busy_i;
    endsequence

    a_prescale_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && !cfg_wr && $stable(baud_rate_select) |-> pre_cnt < prescale)
        else $error("prescaler count passed its factor");

    a_tx_bit_period: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        bit_event[0] && seen[0]
        |-> gap[0] + 32'h0000_0001
            == period(baud_rate_select.transmit_rate_field, transmit_fine_divider))
        else $error("transmit bit period wrong");

    a_rx_bit_period: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        bit_event[1] && seen[1]
        |-> gap[1] + 32'h0000_0001
            == period(baud_rate_select.receive_rate_field, receive_fine_divider))
        else $error("receive bit period wrong");

    a_reset_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !written |-> baud_rate_select == sbg_pkg::RST_BAUD
                     && receive_fine_divider == sbg_pkg::RST_FINE
                     && transmit_fine_divider == sbg_pkg::RST_FINE)
        else $error("divider registers not zero before first write");

    a_baud_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        wr_take && reg_idx == sbg_pkg::IDX_BAUD
        |=> baud_rate_select == $past(avs_writedata_i[7:0]))
        else $error("baud register write lost");

    a_drain_wait: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_drain_enter ##1 (byte_busy_i && serial_control_one[sbg_pkg::POS_LOW_POWER])
        |-> lp_state == sbg_pkg::LP_DRAIN ##1 serial_enable_o)
        else $error("stopped before byte ended");

    a_stop_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (lp_state != sbg_pkg::LP_RUN) ##0 s_byte_done
        |=> lp_state == sbg_pkg::LP_STOP ##1 (!serial_enable_o && !tx_bit_tick_o
                                               && !rx_bit_tick_o))
        else $error("outputs still active after low-power stop");

    a_wait_answer: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(bus_req) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle after request");

    a_dir_apart: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        run && !cfg_wr && !pre_tick
        |=> $stable(g_dir[0].div_cnt) && $stable(g_dir[1].div_cnt))
        else $error("divider chain moved without a prescaler tick");

endmodule

// *** logic/sbg_pkg.sv ***
package sbg_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [6:0] IDX_STATUS   = 7'h50;
    localparam logic [6:0] IDX_DATA     = 7'h51;
    localparam logic [6:0] IDX_BAUD     = 7'h52;
    localparam logic [6:0] IDX_CTRL_ONE = 7'h53;
    localparam logic [6:0] IDX_CTRL_TWO = 7'h54;
    localparam logic [6:0] IDX_RX_FINE  = 7'h56;
    localparam logic [6:0] IDX_TX_FINE  = 7'h57;
    localparam logic [6:0] IDX_GEN_STAT = 7'h58;

    localparam logic [7:0] RST_STATUS   = 8'hC0;
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [7:0] RST_BAUD     = 8'h00;
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] RST_FINE     = 8'h00;

    localparam int         POS_LOW_POWER = 5;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam int         OVERSAMPLE = 16;

    localparam logic [3:0] PRESCALE_00 = 4'h1;
    localparam logic [3:0] PRESCALE_01 = 4'h3;
    localparam logic [3:0] PRESCALE_10 = 4'h4;
    localparam logic [3:0] PRESCALE_11 = 4'hD;

    typedef struct packed {
        logic [1:0] first_prescaler_field;
        logic [2:0] transmit_rate_field;
        logic [2:0] receive_rate_field;
    } sbg_baud_t;

    typedef enum logic [1:0] {
        LP_RUN   = 2'b00,
        LP_DRAIN = 2'b01,
        LP_STOP  = 2'b11
    } sbg_lp_state_t;

    function automatic logic [3:0] prescale_factor(input logic [1:0] code);
        case (code)
            2'b00:   prescale_factor = PRESCALE_00;
            2'b01:   prescale_factor = PRESCALE_01;
            2'b10:   prescale_factor = PRESCALE_10;
            default: prescale_factor = PRESCALE_11;
        endcase
    endfunction

endpackage

// *** dv/sbg_frame_model.sv ***
module sbg_frame_model (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    input  wire logic bit_tick_i,
    output logic      byte_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] bits_left;

    // ten bit times per frame: start, eight data, stop
    // frames begin only when the bench asks, never around a divider change
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bits_left <= 4'h0;
        end else if (start_i && bits_left == 4'h0) begin
            bits_left <= 4'hA;
        end else if (bit_tick_i && bits_left != 4'h0) begin
            bits_left <= bits_left - 4'h1;
        end
    end

    assign byte_busy_o = (bits_left != 4'h0);
endmodule

// *** dv/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [8:0]  address   = 9'h000;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [3:0]  be        = 4'hF;
    logic [31:0] wdata     = 32'h0000_0000;
    logic        start     = 1'b0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        tx_tick;
    logic        rx_tick;
    logic        ser_en;
    logic        busy;
    logic [7:0]  holding;
    int          n_errors  = 0;
    int          compares  = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    sbg_baud_gen u_sbg_baud_gen (
        .clk_sys_i        (clk_sys_i),
        .rstn_i           (rstn_i),
        .avs_address_i    (address),
        .avs_read_i       (rd),
        .avs_write_i      (wr),
        .avs_byteenable_i (be),
        .avs_writedata_i  (wdata),
        .avs_readdata_o   (rdata),
        .avs_waitrequest_o(waitreq),
        .byte_busy_i      (busy),
        .tx_bit_tick_o    (tx_tick),
        .rx_bit_tick_o    (rx_tick),
        .serial_enable_o  (ser_en),
        .tx_holding_o     (holding)
    );

    sbg_frame_model u_sbg_frame_model (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .start_i    (start),
        .bit_tick_i (tx_tick),
        .byte_busy_o(busy)
    );

    task automatic stop_test;
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic access(input logic is_wr, input logic [6:0] idx, input logic [7:0] d,
                          input logic [3:0] en, output logic [31:0] q);
        int n;
        @(posedge clk_sys_i);
        address <= {idx, 2'b00};
        wdata   <= {24'h00_0000, d};
        be      <= en;
        wr      <= is_wr;
        rd      <= !is_wr;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        q = rdata;
        if (n >= 64) n_errors++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [6:0] idx, input logic [7:0] d, input logic [3:0] en);
        logic [31:0] q;
        access(1'b1, idx, d, en, q);
    endtask

    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        access(1'b0, idx, 8'h00, 4'hF, q);
        check(q, {24'h00_0000, exp});
    endtask

    // first tick after a restart may be short, so time the second gap
    task automatic period(input logic use_tx, output int n);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while ((use_tx ? tx_tick : rx_tick) !== 1'b1 && n < 20000);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while ((use_tx ? tx_tick : rx_tick) !== 1'b1 && n < 20000);
    endtask

    task automatic test_reset;
        rd_chk(sbg_pkg::IDX_BAUD, 8'h00);
        rd_chk(sbg_pkg::IDX_RX_FINE, 8'h00);
        rd_chk(sbg_pkg::IDX_TX_FINE, 8'h00);
        rd_chk(sbg_pkg::IDX_STATUS, 8'hC0);
        rd_chk(sbg_pkg::IDX_CTRL_ONE, 8'h00);
        rd_chk(sbg_pkg::IDX_CTRL_TWO, 8'h00);
        rd_chk(7'h55, 8'h00);
        rd_chk(sbg_pkg::IDX_GEN_STAT, 8'h00);
    endtask

    task automatic test_access;
        wr_reg(sbg_pkg::IDX_DATA, 8'hA5, 4'h1);
        // data register then output copy: two flops behind the write edge
        repeat (2) @(posedge clk_sys_i);
        check(holding, 8'hA5);
        wr_reg(sbg_pkg::IDX_DATA, 8'h3C, 4'h0);
        rd_chk(sbg_pkg::IDX_DATA, 8'hA5);
        wr_reg(sbg_pkg::IDX_STATUS, 8'h00, 4'h1);
        rd_chk(sbg_pkg::IDX_STATUS, 8'hC0);
        wr_reg(7'h55, 8'hFF, 4'h1);
        rd_chk(7'h55, 8'h00);
        wr_reg(sbg_pkg::IDX_CTRL_TWO, 8'hFF, 4'h1);
        rd_chk(sbg_pkg::IDX_CTRL_TWO, 8'hFF);
        wr_reg(sbg_pkg::IDX_CTRL_ONE, 8'h5A, 4'h1);
        rd_chk(sbg_pkg::IDX_CTRL_ONE, 8'h5A);
        wr_reg(sbg_pkg::IDX_CTRL_ONE, 8'h00, 4'h1);
    endtask

    task automatic run_case(input logic [7:0] baud, input logic [7:0] fr,
                            input logic [7:0] ft, input int etx, input int erx);
        int n;
        wr_reg(sbg_pkg::IDX_BAUD, baud, 4'h1);
        wr_reg(sbg_pkg::IDX_RX_FINE, fr, 4'h1);
        wr_reg(sbg_pkg::IDX_TX_FINE, ft, 4'h1);
        rd_chk(sbg_pkg::IDX_BAUD, baud);
        rd_chk(sbg_pkg::IDX_RX_FINE, fr);
        rd_chk(sbg_pkg::IDX_TX_FINE, ft);
        period(1'b1, n);
        check(n, etx);
        period(1'b0, n);
        check(n, erx);
    endtask

    task automatic test_rates;
        run_case(8'h00, 8'h00, 8'h00, 16, 16);
        run_case(8'h40, 8'h00, 8'h00, 48, 48);
        run_case(8'h80, 8'h00, 8'h00, 64, 64);
        run_case(8'hC0, 8'h00, 8'h00, 208, 208);
        run_case(8'h39, 8'h00, 8'h00, 2048, 32);
        run_case(8'h08, 8'h01, 8'hFF, 8160, 16);
        run_case(8'h00, 8'h23, 8'h00, 16, 560);
    endtask

    task automatic test_low_power;
        int n;
        int ticks;
        @(posedge clk_sys_i);
        start <= 1'b1;
        @(posedge clk_sys_i);
        start <= 1'b0;
        wr_reg(sbg_pkg::IDX_CTRL_ONE, 8'h20, 4'h1);
        check(ser_en, 1'b1);
        rd_chk(sbg_pkg::IDX_GEN_STAT, 8'h01);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (busy !== 1'b0 && n < 1000);
        if (n >= 1000) n_errors++;
        repeat (3) @(posedge clk_sys_i);
        check(ser_en, 1'b0);
        rd_chk(sbg_pkg::IDX_GEN_STAT, 8'h03);
        ticks = 0;
        repeat (64) begin
            @(posedge clk_sys_i);
            if (tx_tick === 1'b1 || rx_tick === 1'b1) ticks++;
        end
        check(ticks, 0);
        wr_reg(sbg_pkg::IDX_CTRL_ONE, 8'h00, 4'h1);
        repeat (3) @(posedge clk_sys_i);
        check(ser_en, 1'b1);
        period(1'b1, n);
        check(n, 16);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        test_reset;
        test_access;
        test_rates;
        test_low_power;
        stop_test;
    end

    // longest scenario set needs well under half of this span
    initial begin
        repeat (80000) @(posedge clk_sys_i);
        n_errors++;
        stop_test;
    end
endmodule
